//--- src/wfpf_consts.svh
`ifndef WFPF_CONSTS_SVH
`define WFPF_CONSTS_SVH
// ==========================================
// Register map (byte addresses)
`define WFPF_STAT_ADDR    12'h140
`define WFPF_CTRL_ADDR    12'h148
`define WFPF_CFG_FIRST    12'h150
`define WFPF_CFG_LAST     12'h1CC
`define WFPF_MASK_FIRST   12'h200
`define WFPF_MASK_LAST    12'h3FC
`define WFPF_PF_FIRST     12'h400
`define WFPF_PF_LAST      12'h504
// ==========================================
// Sizes
`define WFPF_NFILT        32
`define WFPF_NPF          33
`define WFPF_MASK_BITS    128
// ==========================================
// Filter config fields
`define WFPF_CFG_EN_BIT   31
`define WFPF_CFG_AT_HI    25
`define WFPF_CFG_AT_LO    24
`define WFPF_CFG_OFS_HI   23
`define WFPF_CFG_OFS_LO   16
`define WFPF_CFG_CRC_HI   15
`define WFPF_CFG_CRC_LO   0
`define WFPF_CFG_RW_MASK  32'h83FFFFFF
// ==========================================
// Perfect entry fields
`define WFPF_PF_VALID_BIT 31
`define WFPF_PF_SRC_BIT   30
`define WFPF_PF_HI_RW     32'hC000FFFF
// ==========================================
// Status and control fields
`define WFPF_ST_WF_BIT    8
`define WFPF_ST_PD_BIT    11
`define WFPF_CTRL_WF_BIT  0
`define WFPF_CTRL_PD_BIT  1
`define WFPF_CTRL_RW      32'h00000003
// ==========================================
// Reset values
`define WFPF_WORD_RST     32'h00000000
`define WFPF_MASK_RST     128'h0
// ==========================================
// Frame handling
`define WFPF_CRC_POLY     16'h8005
`define WFPF_CRC_INIT     16'hFFFF
`define WFPF_DA_BYTES     9'h006
`define WFPF_HDR_BYTES    9'h00C
`define WFPF_CNT_MAX      9'h1FF
`endif

//--- src/wfpf_crc16.sv
`timescale 1ns/1ps
`default_nettype none
`include "wfpf_consts.svh"
// ==========================================
// One byte step of the pattern CRC
module wfpf_crc16
  import wfpf_pkg::*;
(
  input  wire logic [7:0] data_in,  // Frame byte
  input  wire wfpf_crc_t  crc_in,   // Running CRC
  output var  wfpf_crc_t  crc_out   // CRC after byte
);
  // Bits enter in wire order, bit 0 first
  always_comb
  begin
    wfpf_crc_t c;
    logic      fb;
    c  = crc_in;
    fb = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      fb = c[15] ^ data_in[k];
      c  = {c[14:0], 1'b0} ^ (fb ? `WFPF_CRC_POLY : 16'h0000);
    end
    crc_out = c;
  end
endmodule : wfpf_crc16
`default_nettype wire

//--- src/wfpf_pkg.sv
// ==========================================
// Shared types
package wfpf_pkg;
  typedef enum logic [1:0] {
    WFPF_IDLE = 2'b00,
    WFPF_RECV = 2'b01,
    WFPF_EVAL = 2'b10
  } wfpf_state_t;
  typedef logic [15:0] wfpf_crc_t;
  typedef logic [31:0] wfpf_word_t;
endpackage : wfpf_pkg

//--- src/wfpf_top.sv
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "wfpf_consts.svh"
// Contract
// - 32 filters, patterns up to 128 bytes
// - One config word each, bit 31 enables
// - Bits 25:24 qualify unicast, multicast or all
// - Bits 23:16 give CRC start byte
// - Bits 15:0 expected CRC, equality means wake
// - Set mask bit j includes byte offset+j
// - Mask as four words, low word first
// - Filter 0 defaults from EEPROM, OTP, else zero
// - USB or lite reset restores filter 0 image
// - Only valid entries take part in matching
// - Bit 30 picks source or destination address
// - Two words per entry, high then low
// - Report matching filter index, five bits
// - Physical destination match sets its wake flag
module wfpf_top
  import wfpf_pkg::*;
(
  input  wire logic         MCLK,                   // Clock
  input  wire logic         RST_N,                  // Reset, active low
  input  wire logic         USB_RESET,              // USB reset pulse
  input  wire logic         LITE_RESET,             // Lite reset pulse
  input  wire logic         IMG_LOAD,               // Image load pulse
  input  wire logic         EE_VALID,               // EEPROM image present
  input  wire logic [31:0]  EE_CFG,                 // EEPROM filter 0 config
  input  wire logic [127:0] EE_MASK,                // EEPROM filter 0 mask
  input  wire logic         OTP_VALID,              // OTP image present
  input  wire logic [31:0]  OTP_CFG,                // OTP filter 0 config
  input  wire logic [127:0] OTP_MASK,               // OTP filter 0 mask
  input  wire logic         WB_CYC_I,               // Bus cycle
  input  wire logic         WB_STB_I,               // Bus strobe
  input  wire logic         WB_WE_I,                // Write enable
  input  wire logic [11:0]  WB_ADR_I,               // Byte address
  input  wire logic [3:0]   WB_SEL_I,               // Byte enables
  input  wire logic [31:0]  WB_DAT_I,               // Write data
  output var  logic [31:0]  WB_DAT_O,               // Read data
  output var  logic         WB_ACK_O,               // Acknowledge
  input  wire logic         RX_VALID,               // Byte strobe
  input  wire logic         RX_SOF,                 // First byte
  input  wire logic         RX_EOF,                 // Last byte
  input  wire logic         RX_ERR,                 // Frame error at last
  input  wire logic [7:0]   RX_DATA,                // Frame byte
  input  wire logic [47:0]  PHYS_ADDR,              // Own MAC address
  output var  logic         WAKE_FRAME_SEEN,        // Wake frame pulse
  output var  logic [4:0]   MATCH_INDEX,            // Matching filter
  output var  logic         PERFECT_DEST_WAKE_SEEN, // Own DA wake pulse
  output var  logic         PF_MATCH                // Perfect match pulse
);
  // ==========================================
  // Storage
  logic [31:0]               cfg_ff   [0:`WFPF_NFILT-1];
  logic [`WFPF_MASK_BITS-1:0] mask_ff [0:`WFPF_NFILT-1];
  logic [31:0]               pf_hi_ff [0:`WFPF_NPF-1];
  logic [31:0]               pf_lo_ff [0:`WFPF_NPF-1];
  wfpf_crc_t                 crc_ff   [0:`WFPF_NFILT-1];
  wfpf_crc_t                 crc_nxt  [0:`WFPF_NFILT-1];
  logic [31:0]               img_cfg_ff;
  logic [`WFPF_MASK_BITS-1:0] img_mask_ff;
  logic [31:0]               img_cfg_now;
  logic [`WFPF_MASK_BITS-1:0] img_mask_now;
  logic [1:0]                ctrl_ff;
  logic                      wf_st_ff;
  logic                      pd_st_ff;
  logic [4:0]                idx_st_ff;
  wfpf_state_t               state_ff;
  logic [8:0]                cnt_ff;
  logic                      err_ff;
  logic [95:0]               addr_ff;
  logic [`WFPF_NFILT-1:0]    hit;
  logic [`WFPF_NFILT-1:0]    type_ok;
  logic [`WFPF_NPF-1:0]      pf_hit;
  logic [`WFPF_NPF-1:0]      pf_valid;
  logic                      soft_rst;
  logic                      bus_req;
  logic                      bus_wr;
  logic                      aligned;
  logic                      dec_cfg;
  logic                      dec_mask;
  logic                      dec_pf;
  logic                      dec_stat;
  logic                      dec_ctrl;
  logic [11:0]               off_cfg;
  logic [11:0]               off_mask;
  logic [11:0]               off_pf;
  logic [31:0]               bem;
  logic [31:0]               rd_word;
  logic [31:0]               stat_word;
  logic                      take;
  logic                      sof_take;
  logic [8:0]                cur_idx;
  logic [47:0]               da;
  logic [47:0]               sa;
  logic                      wf_fire;
  logic                      pd_fire;
  logic                      pf_fire;
  logic [4:0]                first_idx;

  // Lowest numbered hit wins the index
  function automatic logic [4:0] first_hit(input logic [`WFPF_NFILT-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int k = `WFPF_NFILT - 1; k >= 0; k--)
      if (v[k])
        r = 5'(k);
    return r;
  endfunction : first_hit

  // ==========================================
  // Bus decode
  assign soft_rst = USB_RESET | LITE_RESET;
  assign bus_req  = WB_CYC_I & WB_STB_I;
  assign bus_wr   = bus_req & WB_WE_I & WB_ACK_O;  // Commits in ack cycle
  assign aligned  = (WB_ADR_I[1:0] == 2'b00);
  assign off_cfg  = WB_ADR_I - `WFPF_CFG_FIRST;
  assign off_mask = WB_ADR_I - `WFPF_MASK_FIRST;
  assign off_pf   = WB_ADR_I - `WFPF_PF_FIRST;
  assign dec_cfg  = aligned && WB_ADR_I >= `WFPF_CFG_FIRST && WB_ADR_I <= `WFPF_CFG_LAST;
  assign dec_mask = aligned && WB_ADR_I >= `WFPF_MASK_FIRST && WB_ADR_I <= `WFPF_MASK_LAST;
  assign dec_pf   = aligned && WB_ADR_I >= `WFPF_PF_FIRST && WB_ADR_I <= `WFPF_PF_LAST;
  assign dec_stat = (WB_ADR_I == `WFPF_STAT_ADDR);
  assign dec_ctrl = (WB_ADR_I == `WFPF_CTRL_ADDR);
  assign bem      = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // Status word layout
  always_comb
  begin
    stat_word = `WFPF_WORD_RST;
    stat_word[`WFPF_ST_WF_BIT] = wf_st_ff;
    stat_word[`WFPF_ST_PD_BIT] = pd_st_ff;
    stat_word[4:0] = idx_st_ff;
  end

  // Read mux, unmapped reads as zero
  always_comb
  begin
    rd_word = `WFPF_WORD_RST;
    if (dec_cfg)
      rd_word = cfg_ff[off_cfg[6:2]];
    else if (dec_mask)
      rd_word = mask_ff[off_mask[8:4]][{off_mask[3:2], 5'h00} +: 32];
    else if (dec_pf)
      rd_word = off_pf[2] ? pf_lo_ff[off_pf[8:3]] : pf_hi_ff[off_pf[8:3]];
    else if (dec_stat)
      rd_word = stat_word;
    else if (dec_ctrl)
      rd_word = {30'h00000000, ctrl_ff};
  end

  // Classic slave: ack one cycle after request
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= `WFPF_WORD_RST;
    end
    else
    begin
      WB_ACK_O <= bus_req & ~WB_ACK_O;
      if (bus_req & ~WB_ACK_O)
        WB_DAT_O <= rd_word;
    end
  end

  // ==========================================
  // Filter 0 image selection
  always_comb
  begin
    img_cfg_now  = img_cfg_ff;
    img_mask_now = img_mask_ff;
    if (IMG_LOAD)
    begin
      img_cfg_now  = (EE_VALID ? EE_CFG : (OTP_VALID ? OTP_CFG : `WFPF_WORD_RST))
                     & `WFPF_CFG_RW_MASK;
      img_mask_now = EE_VALID ? EE_MASK : (OTP_VALID ? OTP_MASK : `WFPF_MASK_RST);
    end
  end

  // Image survives USB and lite resets
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      img_cfg_ff  <= `WFPF_WORD_RST;
      img_mask_ff <= `WFPF_MASK_RST;
    end
    else
    begin
      img_cfg_ff  <= img_cfg_now;
      img_mask_ff <= img_mask_now;
    end
  end

  // ==========================================
  // Frame sequencing
  assign sof_take = RX_VALID & RX_SOF;
  assign take     = RX_VALID & (RX_SOF | (state_ff == WFPF_RECV));
  assign cur_idx  = RX_SOF ? 9'h000 : cnt_ff;
  assign da       = addr_ff[47:0];
  assign sa       = addr_ff[95:48];

  // New start always restarts the frame
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      state_ff <= WFPF_IDLE;
    else
      case (state_ff)
        WFPF_IDLE, WFPF_EVAL:
          if (sof_take)
            state_ff <= RX_EOF ? WFPF_EVAL : WFPF_RECV;
          else
            state_ff <= WFPF_IDLE;
        WFPF_RECV:
          if (RX_VALID & RX_EOF)
            state_ff <= WFPF_EVAL;
          else if (sof_take)
            state_ff <= WFPF_RECV;
        default:
          state_ff <= WFPF_IDLE;
      endcase
  end

  // Byte count, error flag, address capture
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cnt_ff  <= 9'h000;
      err_ff  <= 1'b0;
      addr_ff <= 96'h0;
    end
    else if (take)
    begin
      cnt_ff <= (cur_idx == `WFPF_CNT_MAX) ? `WFPF_CNT_MAX : cur_idx + 9'h001;
      if (RX_EOF)
        err_ff <= RX_ERR;
      if (cur_idx < `WFPF_HDR_BYTES)
        addr_ff[{cur_idx[3:0], 3'b000} +: 8] <= RX_DATA;
    end
  end

  // ==========================================
  // Wakeup filters
  for (genvar gi = 0; gi < `WFPF_NFILT; gi++)
  begin : g_filt
    logic [7:0] ofs;
    logic [8:0] rel;
    logic       inc;
    assign ofs = cfg_ff[gi][`WFPF_CFG_OFS_HI:`WFPF_CFG_OFS_LO];
    assign rel = cur_idx - {1'b0, ofs};
    assign inc = (cur_idx >= {1'b0, ofs}) && (rel[8:7] == 2'b00)
                 && mask_ff[gi][rel[6:0]];
    assign type_ok[gi] = cfg_ff[gi][`WFPF_CFG_AT_LO]
                 || (cfg_ff[gi][`WFPF_CFG_AT_HI] == addr_ff[0]);
    assign hit[gi] = cfg_ff[gi][`WFPF_CFG_EN_BIT] && type_ok[gi] && !err_ff
                 && (crc_ff[gi] == cfg_ff[gi][`WFPF_CFG_CRC_HI:`WFPF_CFG_CRC_LO]);

    wfpf_crc16 u_crc (
      .data_in (RX_DATA),
      .crc_in  (RX_SOF ? `WFPF_CRC_INIT : crc_ff[gi]),
      .crc_out (crc_nxt[gi])
    );

    // CRC over masked bytes only
    always_ff @(posedge MCLK)
    begin
      if (!RST_N)
        crc_ff[gi] <= `WFPF_CRC_INIT;
      else if (take)
        crc_ff[gi] <= inc ? crc_nxt[gi] : (RX_SOF ? `WFPF_CRC_INIT : crc_ff[gi]);
    end

    // Config and mask words
    always_ff @(posedge MCLK)
    begin
      if (!RST_N)
      begin
        cfg_ff[gi]  <= `WFPF_WORD_RST;
        mask_ff[gi] <= `WFPF_MASK_RST;
      end
      else if (soft_rst || (gi == 0 && IMG_LOAD))
      begin
        cfg_ff[gi]  <= (gi == 0) ? img_cfg_now : `WFPF_WORD_RST;
        mask_ff[gi] <= (gi == 0) ? img_mask_now : `WFPF_MASK_RST;
      end
      else if (bus_wr && dec_cfg && off_cfg[6:2] == 5'(gi))
        cfg_ff[gi] <= ((cfg_ff[gi] & ~bem) | (WB_DAT_I & bem)) & `WFPF_CFG_RW_MASK;
      else if (bus_wr && dec_mask && off_mask[8:4] == 5'(gi))
        mask_ff[gi][{off_mask[3:2], 5'h00} +: 32] <=
          (mask_ff[gi][{off_mask[3:2], 5'h00} +: 32] & ~bem) | (WB_DAT_I & bem);
    end
  end

  // ==========================================
  // Perfect address entries
  for (genvar ge = 0; ge < `WFPF_NPF; ge++)
  begin : g_pf
    assign pf_valid[ge] = pf_hi_ff[ge][`WFPF_PF_VALID_BIT];
    assign pf_hit[ge] = pf_valid[ge]
      && ((pf_hi_ff[ge][`WFPF_PF_SRC_BIT] ? sa : da)
          == {pf_hi_ff[ge][15:0], pf_lo_ff[ge]});

    // High and low words of one entry
    always_ff @(posedge MCLK)
    begin
      if (!RST_N || soft_rst)
      begin
        pf_hi_ff[ge] <= `WFPF_WORD_RST;
        pf_lo_ff[ge] <= `WFPF_WORD_RST;
      end
      else if (bus_wr && dec_pf && off_pf[8:3] == 6'(ge))
      begin
        if (off_pf[2])
          pf_lo_ff[ge] <= (pf_lo_ff[ge] & ~bem) | (WB_DAT_I & bem);
        else
          pf_hi_ff[ge] <= ((pf_hi_ff[ge] & ~bem) | (WB_DAT_I & bem)) & `WFPF_PF_HI_RW;
      end
    end
  end

  // ==========================================
  // Frame verdicts
  assign first_idx = first_hit(hit);
  assign wf_fire = (state_ff == WFPF_EVAL) && (|hit) && ctrl_ff[`WFPF_CTRL_WF_BIT];
  assign pd_fire = (state_ff == WFPF_EVAL) && !err_ff && cnt_ff >= `WFPF_DA_BYTES
                   && da == PHYS_ADDR && ctrl_ff[`WFPF_CTRL_PD_BIT];
  assign pf_fire = (state_ff == WFPF_EVAL) && !err_ff && cnt_ff >= `WFPF_HDR_BYTES
                   && (|pf_hit);

  // Event pulses and index
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      WAKE_FRAME_SEEN        <= 1'b0;
      PERFECT_DEST_WAKE_SEEN <= 1'b0;
      PF_MATCH               <= 1'b0;
      MATCH_INDEX            <= 5'h00;
    end
    else
    begin
      WAKE_FRAME_SEEN        <= wf_fire;
      PERFECT_DEST_WAKE_SEEN <= pd_fire;
      PF_MATCH               <= pf_fire;
      if (wf_fire)
        MATCH_INDEX <= first_idx;
    end
  end

  // Sticky status, set beats clear
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      wf_st_ff  <= 1'b0;
      pd_st_ff  <= 1'b0;
      idx_st_ff <= 5'h00;
      ctrl_ff   <= 2'b00;
    end
    else
    begin
      wf_st_ff <= wf_fire | (wf_st_ff
                  & ~(bus_wr & dec_stat & bem[`WFPF_ST_WF_BIT] & WB_DAT_I[`WFPF_ST_WF_BIT]));
      pd_st_ff <= pd_fire | (pd_st_ff
                  & ~(bus_wr & dec_stat & bem[`WFPF_ST_PD_BIT] & WB_DAT_I[`WFPF_ST_PD_BIT]));
      if (wf_fire)
        idx_st_ff <= first_idx;
      if (bus_wr && dec_ctrl)
        ctrl_ff <= 2'(((({30'h0, ctrl_ff} & ~bem) | (WB_DAT_I & bem))) & `WFPF_CTRL_RW);
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  property p_wake_cause;
    WAKE_FRAME_SEEN |-> $past(state_ff == WFPF_EVAL && !err_ff && (|hit));
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake pulse without qualified hit");

  property p_err_block;
    (state_ff == WFPF_EVAL && err_ff) |=> !WAKE_FRAME_SEEN && !PERFECT_DEST_WAKE_SEEN;
  endproperty
  a_err_block: assert property (p_err_block)
    else $error("errored frame caused wake");

  property p_index;
    wf_fire |=> WAKE_FRAME_SEEN && MATCH_INDEX == $past(first_idx)
                && wf_st_ff && idx_st_ff == MATCH_INDEX;
  endproperty
  a_index: assert property (p_index)
    else $error("filter index not reported");

  property p_enable;
    (state_ff == WFPF_EVAL && !cfg_ff[0][`WFPF_CFG_EN_BIT]) |-> !hit[0];
  endproperty
  a_enable: assert property (p_enable)
    else $error("disabled filter matched");

  property p_pd;
    pd_fire |=> PERFECT_DEST_WAKE_SEEN && pd_st_ff ##1 !PERFECT_DEST_WAKE_SEEN || pd_fire;
  endproperty
  a_pd: assert property (p_pd)
    else $error("perfect destination wake not flagged");

  property p_pf_valid;
    PF_MATCH |-> $past(|pf_valid && !err_ff);
  endproperty
  a_pf_valid: assert property (p_pf_valid)
    else $error("perfect match without valid entry");

  property p_soft_f0;
    (soft_rst && !IMG_LOAD) |=> cfg_ff[0] == img_cfg_ff && mask_ff[0] == img_mask_ff;
  endproperty
  a_soft_f0: assert property (p_soft_f0)
    else $error("filter 0 not restored from image");

  property p_no_image;
    (IMG_LOAD && !EE_VALID && !OTP_VALID) |=> cfg_ff[0] == `WFPF_WORD_RST
                                              && mask_ff[0] == `WFPF_MASK_RST;
  endproperty
  a_no_image: assert property (p_no_image)
    else $error("filter 0 not zero without image");

  property p_cfg_wr;
    (bus_wr && dec_cfg && off_cfg[6:2] == 5'h00 && WB_SEL_I == 4'hF && !soft_rst && !IMG_LOAD)
      |=> cfg_ff[0] == ($past(WB_DAT_I) & `WFPF_CFG_RW_MASK);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("config write lost");

  c_wake: cover property (WAKE_FRAME_SEEN);
  c_pd:   cover property (PERFECT_DEST_WAKE_SEEN);
  c_pf:   cover property (PF_MATCH);
  c_soft: cover property (soft_rst ##1 (cfg_ff[0] == img_cfg_ff));
endmodule : wfpf_top
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench for the wake and perfect filters
module tb
  import wfpf_pkg::*;
  ;
  logic         MCLK, RST_N, usb, lite, img, eev, otpv, cyc, stb, we, ack;
  logic         rxv, sof, eof, err, wk, pd, pf;
  logic [31:0]  ecfg, ocfg, dw, dr;
  logic [127:0] emask, omask;
  logic [11:0]  adr;
  logic [3:0]   sel;
  logic [7:0]   rxd;
  logic [47:0]  phys;
  logic [4:0]   idx;
  int           fails = 0, total_checks = 0, nwk = 0, npd = 0, npf = 0;

  wfpf_top dut (.MCLK(MCLK), .RST_N(RST_N), .USB_RESET(usb), .LITE_RESET(lite),
    .IMG_LOAD(img), .EE_VALID(eev), .EE_CFG(ecfg), .EE_MASK(emask), .OTP_VALID(otpv),
    .OTP_CFG(ocfg), .OTP_MASK(omask), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .RX_VALID(rxv), .RX_SOF(sof), .RX_EOF(eof), .RX_ERR(err), .RX_DATA(rxd),
    .PHYS_ADDR(phys), .WAKE_FRAME_SEEN(wk), .MATCH_INDEX(idx),
    .PERFECT_DEST_WAKE_SEEN(pd), .PF_MATCH(pf));
  wfpf_rx_model rx (.clk(MCLK), .valid(rxv), .sof(sof), .eof(eof), .err(err), .data(rxd));

  always #2 MCLK = ~MCLK;
  // Pulse counters
  always @(posedge MCLK)
  begin
    nwk <= nwk + int'(wk === 1'b1);
    npd <= npd + int'(pd === 1'b1);
    npf <= npf + int'(pf === 1'b1);
  end

  task automatic stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One classic bus cycle, waits for the acknowledge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge MCLK);
    {cyc, stb, we, adr, dw, sel} <= {2'b11, w, a, d, 4'hF};
    // Only the watchdog ends a wait that never sees ack
    do
      @(posedge MCLK);
    while (ack !== 1'b1);
    q = dr;
    {cyc, stb} <= 2'b00;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdc

  // Pulse lite, usb or image load for one cycle
  task automatic pulse(input int w);
    @(posedge MCLK);
    {img, usb, lite} <= 3'(1 << w);
    @(posedge MCLK);
    {img, usb, lite} <= 3'h0;
  endtask : pulse

  task automatic img0(input logic [31:0] c, input logic [127:0] m);
    rdc(12'h150, c & 32'h83FFFFFF);
    for (int k = 0; k < 4; k++)
      rdc(12'h200 + 12'(4 * k), m[32 * k +: 32]);
  endtask : img0

  // Send a frame and count the pulses it causes
  task automatic frm(input int n, input logic bad, input int ewk, input int epd, input int epf);
    int a, b, c;
    a = nwk;
    b = npd;
    c = npf;
    rx.send(n, bad, 1'($urandom % 2));
    repeat (5) @(posedge MCLK);
    chk(32'(nwk - a), 32'(ewk));
    chk(32'(npd - b), 32'(epd));
    chk(32'(npf - c), 32'(epf));
  endtask : frm

  // Expected pattern CRC over the masked bytes
  function automatic logic [15:0] crc_of(input int ofs, input logic [127:0] m);
    logic [15:0] c;
    logic        fb;
    c = 16'hFFFF;
    for (int j = 0; j < 128; j++)
      for (int b = 0; b < 8; b++)
      begin
        fb = c[15] ^ rx.frame[ofs + j][b];
        if (m[j])
          c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      end
    return c;
  endfunction : crc_of

  initial
  begin
    #100000;
    fails++;
    stop_test();
  end

  initial
  begin
    logic [31:0] q, cf, m[4];
    logic [47:0] da, sa;
    int          fi, ofs, e;
    logic        hit;
    void'($urandom(32'h65B6));
    {MCLK, RST_N, usb, lite, img, eev, otpv, cyc, stb, we} = '0;
    {ecfg, ocfg, emask, omask, dw, adr, sel, phys} = '0;
    repeat (12) @(posedge MCLK);
    RST_N <= 1'b1;
    // Reset values, unmapped place, writable bits
    rdc(12'h150, 32'h0);
    rdc(12'h204, 32'h0);
    rdc(12'h400, 32'h0);
    wr(12'h600, 32'hFFFFFFFF);
    rdc(12'h600, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      q = $urandom;
      fi = $urandom % 32;
      e = $urandom % 33;
      wr(12'h150 + 12'(4 * fi), q);
      rdc(12'h150 + 12'(4 * fi), q & 32'h83FFFFFF);
      wr(12'h400 + 12'(8 * e), q);
      rdc(12'h400 + 12'(8 * e), q & 32'hC000FFFF);
      wr(12'h404 + 12'(8 * e), ~q);
      rdc(12'h404 + 12'(8 * e), ~q);
    end
    pulse(1);
    rdc(12'h400 + 12'(8 * e), 32'h0);
    // Filter 0 image sources and restore on soft resets
    ocfg <= $urandom;
    omask <= {$urandom, $urandom, $urandom, $urandom};
    ecfg <= $urandom;
    emask <= {$urandom, $urandom, $urandom, $urandom};
    otpv <= 1'b1;
    pulse(2);
    img0(ocfg, omask);
    eev <= 1'b1;
    pulse(2);
    img0(ecfg, emask);
    for (int r = 0; r < 2; r++)
    begin
      wr(12'h150, ~ecfg);
      wr(12'h208, ~emask[95:64]);
      pulse(r);
      img0(ecfg, emask);
    end
    {eev, otpv} <= 2'b00;
    pulse(2);
    pulse(1);
    img0(32'h0, 128'h0);
    // Wake filter over address types, then disabled, bad CRC, error, signaling off
    phys <= 48'({$urandom, $urandom});
    wr(12'h148, 32'h3);
    for (int i = 0; i < 256; i++)
      rx.frame[i] = 8'($urandom);
    fi = 1 + $urandom % 31;
    for (int k = 0; k < 12; k++)
    begin
      ofs = $urandom % 40;
      for (int w = 0; w < 4; w++)
        m[w] = $urandom;
      // Errored case is multicast, so only the error may block it
      rx.frame[0][0] = k[2] || k == 10;
      cf = {6'h20, k[1:0], 8'(ofs), crc_of(ofs, {m[3], m[2], m[1], m[0]})};
      cf[31] = k != 8;
      cf[0] = cf[0] ^ (k == 9);
      if (k == 11)
        wr(12'h148, 32'h2);
      for (int w = 0; w < 4; w++)
        wr(12'h200 + 12'(16 * fi + 4 * w), m[w]);
      wr(12'h150 + 12'(4 * fi), cf);
      hit = k < 8 && (k[0] || k[1] == k[2]);
      frm(200, k == 10, hit, 0, 0);
      if (hit)
        chk(32'(idx), 32'(fi));
    end
    // Perfect entries on each field, own address, frame length edges
    wr(12'h148, 32'h3);
    wr(12'h150 + 12'(4 * fi), 32'h0);
    da = {rx.frame[5], rx.frame[4], rx.frame[3], rx.frame[2], rx.frame[1], rx.frame[0]};
    sa = {rx.frame[11], rx.frame[10], rx.frame[9], rx.frame[8], rx.frame[7], rx.frame[6]};
    phys <= da;
    e = $urandom % 33;
    for (int k = 0; k < 5; k++)
    begin
      cf = {k[0] || k == 4, k[1] || k == 4, 14'h0, (k[1] ? sa[47:32] : da[47:32])};
      wr(12'h400 + 12'(8 * e), {1'b0, cf[30:0]});
      wr(12'h404 + 12'(8 * e), k[1] ? sa[31:0] : da[31:0]);
      wr(12'h400 + 12'(8 * e), cf);
      frm(200, 1'b0, 0, 1, k[0]);
    end
    wr(12'h400 + 12'(8 * e), {16'h8000, da[47:32]});
    frm(5, 1'b0, 0, 0, 0);
    frm(6, 1'b0, 0, 1, 0);
    frm(11, 1'b0, 0, 1, 0);
    frm(12, 1'b0, 0, 1, 1);
    frm(12, 1'b1, 0, 0, 0);
    stop_test();
  end
endmodule : tb
`default_nettype wire

//--- testbench/wfpf_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Receive datapath model
module wfpf_rx_model
(
  input  wire logic       clk,   // Clock
  output var  logic       valid, // Byte strobe
  output var  logic       sof,   // First byte
  output var  logic       eof,   // Last byte
  output var  logic       err,   // Error flag
  output var  logic [7:0] data   // Frame byte
);
  logic [7:0] frame [256];
  initial {valid, sof, eof, err, data} = 12'h000;
  // Bytes with optional stalls; idle lines never repeat the last byte
  task automatic send(input int n, input logic bad, input logic gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      {valid, sof, eof, data} <= {1'b1, i == 0, i == n - 1, frame[i]};
      err <= bad && i == n - 1;
      if (gap && i < n - 1)
      begin
        @(posedge clk);
        {valid, data} <= {1'b0, ~frame[i]};
      end
    end
    @(posedge clk);
    {valid, sof, eof, err, data} <= {4'h0, ~frame[n - 1]};
  endtask : send
endmodule : wfpf_rx_model
`default_nettype wire
